/* File: rtl/fault_ind_pkg.sv */
package fault_ind_pkg;
  localparam int unsigned MCLK_HZ          = 250_000_000;
  localparam int unsigned SLOW_FLASH_MS    = 500;
  localparam int unsigned FAST_FLASH_MS    = 100;
  localparam int unsigned ALARM_FLASH_MS   = 250;
  localparam int unsigned SLOW_FLASH_CYC   = MCLK_HZ / 1000 * SLOW_FLASH_MS;
  localparam int unsigned FAST_FLASH_CYC   = MCLK_HZ / 1000 * FAST_FLASH_MS;
  localparam int unsigned ALARM_FLASH_CYC  = MCLK_HZ / 1000 * ALARM_FLASH_MS;
  localparam int unsigned LOG_DEPTH        = 10;
  localparam int unsigned CODE_W           = 7;
  localparam int unsigned TIME_W           = 32;
  localparam int unsigned VALUE_W          = 14;
  localparam logic [CODE_W-1:0] CODE_NONE  = 7'h00;
  localparam logic [1:0] BUS_OFF           = 2'h0;
  localparam logic [1:0] BUS_OK            = 2'h1;
  localparam logic [1:0] BUS_LOCAL         = 2'h2;
  localparam logic [1:0] BUS_NO_MASTER     = 2'h3;

  typedef enum logic [3:0] {
    ST_READY  = 4'b0001,
    ST_WARN   = 4'b0010,
    ST_TRIP   = 4'b0100,
    ST_LOCKED = 4'b1000
  } fault_state_t;

  // Class bits: warn capable, alarm capable, lock capable
  function automatic logic [2:0] fault_class(input logic [CODE_W-1:0] code);
    case (code)
      7'd5, 7'd6, 7'd33, 7'd99:                        fault_class = 3'b100;
      7'd2, 7'd4, 7'd7, 7'd8, 7'd13:                   fault_class = 3'b111;
      7'd14, 7'd15, 7'd16, 7'd35:                      fault_class = 3'b011;
      7'd9, 7'd10, 7'd11, 7'd12, 7'd17, 7'd18, 7'd34, 7'd36: fault_class = 3'b110;
      7'd50, 7'd51, 7'd54, 7'd55, 7'd56:               fault_class = 3'b010;
      default: begin
        if (code >= 7'd37 && code <= 7'd45)
          fault_class = 3'b011;
        else
          fault_class = 3'b000;
      end
    endcase
  endfunction : fault_class
endpackage : fault_ind_pkg

/* File: rtl/drive_fault_indicator_logic.sv */
// What this block does
// - Keep ten most recent faults, oldest displaced
// - Log timestamp, fault code, measured value
// - Status LED off when OK, else setting
// - Bus LED steady on when bus healthy
// - Bus LED slow flash in local mode
// - Bus LED fast flash without master exchange
// - Bus LED off when faulty or absent
// - Alarm LED flashes while trip active
// - Warning LED flashes while warning exists
// - Power LED on with mains or 24V
// - Warning clears itself when cause goes
// - Alarm latches until accepted reset
// - Locked trip flashes both; needs power cycle
// - Trip reset from key, input, serial
// - Automatic reset option clears trips, not locked trips
// - Configurable faults warn or alarm; others escalate
// - Trip coasts motor; cause gone, alarm only
// - After reset, ready to start again
// - Codes 5,6,33,99 warn only
// - Lock capable codes; some never warn
// - Tuning codes alarm only, no lock
// - Codes warn and alarm, never lock
// - Index one newest, index ten oldest
`timescale 1ns/1ps
`default_nettype none
module drive_fault_indicator_logic
  import fault_ind_pkg::*;
#(
  parameter int unsigned SLOW_CYC  = SLOW_FLASH_CYC,
  parameter int unsigned FAST_CYC  = FAST_FLASH_CYC,
  parameter int unsigned ALARM_CYC = ALARM_FLASH_CYC,
  parameter int unsigned DEPTH     = LOG_DEPTH
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic [CODE_W-1:0]  fault_code,
  input  wire logic               fault_active,
  input  wire logic               fault_escalate,
  input  wire logic               fault_lock,
  input  wire logic               thermal_as_alarm,
  input  wire logic [VALUE_W-1:0] measured_value,
  input  wire logic               key_stop_reset,
  input  wire logic               din_reset,
  input  wire logic               serial_reset,
  input  wire logic               auto_reset_en,
  input  wire logic               mains_present,
  input  wire logic               aux24_present,
  input  wire logic               bus_option_fitted,
  input  wire logic [1:0]         bus_status,
  input  wire logic               status_setting,
  input  wire logic [3:0]         log_index,
  output logic                    led_status,
  output logic                    led_bus,
  output logic                    led_alarm,
  output logic                    led_warning,
  output logic                    led_power,
  output logic                    motor_coast,
  output logic                    drive_ready,
  output logic [CODE_W-1:0]       log_code,
  output logic [TIME_W-1:0]       log_time,
  output logic [VALUE_W-1:0]      log_value
);
  // Pin inputs pass a two-stage synchroniser
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {key_stop_reset, din_reset, serial_reset, mains_present, aux24_present, fault_active};
      sync2 <= sync1;
    end
  end
  logic key_s, din_s, ser_s, mains_s, aux_s, act_s;
  assign {key_s, din_s, ser_s, mains_s, aux_s, act_s} = sync2;

  // Reset requests are taken on their rising edge only
  logic [2:0] rst_prev;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      rst_prev <= 3'h0;
    else
      rst_prev <= {key_s, din_s, ser_s};
  end
  logic manual_reset;
  assign manual_reset = |({key_s, din_s, ser_s} & ~rst_prev);

  // Flash dividers, each a free-running toggle
  logic slow_ph;
  logic fast_ph;
  logic alarm_ph;

  flash_divider #(
    .HALF_CYC (SLOW_CYC)
  ) slow_div_u (
    .mclk  (mclk),
    .reset (reset),
    .phase (slow_ph)
  );

  flash_divider #(
    .HALF_CYC (FAST_CYC)
  ) fast_div_u (
    .mclk  (mclk),
    .reset (reset),
    .phase (fast_ph)
  );

  flash_divider #(
    .HALF_CYC (ALARM_CYC)
  ) alarm_div_u (
    .mclk  (mclk),
    .reset (reset),
    .phase (alarm_ph)
  );

  // Fault classification
  logic [2:0] cls;
  logic       can_warn, can_alarm, can_lock, thermal_code;
  assign cls          = fault_class(fault_code);
  assign can_warn     = cls[2];
  assign can_alarm    = cls[1];
  assign can_lock     = cls[0];
  assign thermal_code = (fault_code == 7'd10) || (fault_code == 7'd11);

  // Warn-only codes never trip; tuning codes trip at once
  logic goes_warn, goes_trip;
  always_comb begin
    goes_warn = 1'b0;
    goes_trip = 1'b0;
    if (act_s) begin
      if (thermal_code) begin
        goes_trip = thermal_as_alarm;
        goes_warn = ~thermal_as_alarm;
      end else begin
        goes_warn = can_warn;
        goes_trip = can_alarm && (fault_escalate || !can_warn);
      end
    end
  end

  fault_state_t state, next_state;
  logic         lock_power_lost;
  logic         accepted_reset;
  assign accepted_reset = manual_reset || auto_reset_en;

  always_comb begin
    next_state = state;
    case (state)
      ST_READY, ST_WARN: begin
        if (goes_trip && can_lock && fault_lock)
          next_state = ST_LOCKED;
        else if (goes_trip)
          next_state = ST_TRIP;
        else if (goes_warn)
          next_state = ST_WARN;
        else
          next_state = ST_READY;
      end
      ST_TRIP: begin
        // Reset only takes once the cause has gone
        if (accepted_reset && !act_s)
          next_state = ST_READY;
      end
      ST_LOCKED: begin
        // Mains must be back, else a reset during the outage would count
        if (lock_power_lost && mains_s && manual_reset && !act_s)
          next_state = ST_READY;
      end
      default: next_state = ST_READY;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      state <= ST_READY;
    else
      state <= next_state;
  end

  // Locked trip remembers that mains was removed since locking
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      lock_power_lost <= 1'b0;
    else if (state != ST_LOCKED)
      lock_power_lost <= 1'b0;
    else if (!mains_s)
      lock_power_lost <= 1'b1;
  end

  // Timestamp from the internal clock
  logic [TIME_W-1:0] timestamp;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      timestamp <= '0;
    else
      timestamp <= timestamp + TIME_W'(1);
  end

  // Shift log: entry 0 is newest; each new trip shifts the rest down
  logic [CODE_W-1:0]  mem_code  [DEPTH];
  logic [TIME_W-1:0]  mem_time  [DEPTH];
  logic [VALUE_W-1:0] mem_value [DEPTH];
  logic [VALUE_W-1:0] value_hold;
  logic               log_event;
  assign log_event = (state == ST_READY || state == ST_WARN) &&
                     (next_state == ST_TRIP || next_state == ST_LOCKED);

  // Value sampled one cycle early so it precedes the failure
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      value_hold <= '0;
    else
      value_hold <= measured_value;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_code[i] <= CODE_NONE;
      end
    end else if (log_event) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        mem_code[i] <= mem_code[i-1];
      end
      mem_code[0] <= fault_code;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_time[i] <= '0;
      end
    end else if (log_event) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        mem_time[i] <= mem_time[i-1];
      end
      mem_time[0] <= timestamp;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_value[i] <= '0;
      end
    end else if (log_event) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        mem_value[i] <= mem_value[i-1];
      end
      mem_value[0] <= value_hold;
    end
  end

  // Log read port, index 1..DEPTH; out of range reads zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      log_code  <= CODE_NONE;
      log_time  <= '0;
      log_value <= '0;
    end else if (log_index >= 4'h1 && 32'(log_index) <= DEPTH) begin
      log_code  <= mem_code[log_index - 4'h1];
      log_time  <= mem_time[log_index - 4'h1];
      log_value <= mem_value[log_index - 4'h1];
    end else begin
      log_code  <= CODE_NONE;
      log_time  <= '0;
      log_value <= '0;
    end
  end

  // Indicators
  logic tripped, warn_lit;
  assign tripped  = (state == ST_TRIP) || (state == ST_LOCKED);
  assign warn_lit = (state == ST_WARN) || (state == ST_LOCKED) ||
                    ((state == ST_TRIP) && act_s);

  // Shared phase keeps locked-trip LEDs flashing together
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      led_alarm <= 1'b0;
    else
      led_alarm <= tripped && alarm_ph;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      led_warning <= 1'b0;
    else
      led_warning <= warn_lit && alarm_ph;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      led_power <= 1'b0;
    else
      led_power <= mains_s || aux_s;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      led_status <= 1'b0;
    else
      led_status <= (state != ST_READY) && status_setting;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      motor_coast <= 1'b0;
    else
      motor_coast <= tripped;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      drive_ready <= 1'b0;
    else
      drive_ready <= !tripped;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      led_bus <= 1'b0;
    end else if (!bus_option_fitted) begin
      led_bus <= 1'b0;
    end else begin
      case (bus_status)
        BUS_OK:        led_bus <= 1'b1;
        BUS_LOCAL:     led_bus <= slow_ph;
        BUS_NO_MASTER: led_bus <= fast_ph;
        default:       led_bus <= 1'b0;
      endcase
    end
  end
endmodule : drive_fault_indicator_logic

// Half period in clock cycles; the phase toggles at each wrap
module flash_divider #(
  parameter int unsigned HALF_CYC = 2
) (
  input  wire logic mclk,
  input  wire logic reset,
  output logic      phase
);
  logic [31:0] count;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= 32'h0;
      phase <= 1'b0;
    end else if (count >= 32'(HALF_CYC - 1)) begin
      count <= 32'h0;
      phase <= ~phase;
    end else begin
      count <= count + 32'h1;
    end
  end
endmodule : flash_divider
`default_nettype wire

/* File: tb/reset_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_panel_model (
  input  wire logic       mclk,
  input  wire logic [1:0] src,
  input  wire logic       go,
  output logic            key_stop_reset,
  output logic            din_reset,
  output logic            serial_reset
);
  logic [2:0] hold = 3'h0;
  // Held four cycles so the pin synchroniser cannot miss it
  always @(posedge mclk) begin
    if (go)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign key_stop_reset = (hold != 3'h0) && (src == 2'h0);
  assign din_reset      = (hold != 3'h0) && (src == 2'h1);
  assign serial_reset   = (hold != 3'h0) && (src == 2'h2);
endmodule : reset_panel_model
`default_nettype wire

/* File: tb/drive_fault_indicator_logic_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_fault_indicator_logic_chk
  import fault_ind_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       fault_active,
  input wire logic       key_stop_reset,
  input wire logic       din_reset,
  input wire logic       serial_reset,
  input wire logic       auto_reset_en,
  input wire logic       mains_present,
  input wire logic       aux24_present,
  input wire logic       bus_option_fitted,
  input wire logic [1:0] bus_status,
  input wire logic       led_status,
  input wire logic       led_bus,
  input wire logic       led_alarm,
  input wire logic       led_warning,
  input wire logic       led_power,
  input wire logic       motor_coast,
  input wire logic       drive_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Windows cover the pin synchroniser plus the output register
  sequence s_no_clear;
    (motor_coast && !key_stop_reset && !din_reset && !serial_reset && !auto_reset_en) [*6];
  endsequence
  sequence s_trip_entry;
    $rose(motor_coast);
  endsequence
  AST_POWER_ON: assert property ((mains_present || aux24_present) [*5] |-> led_power)
    else $error("power led dark");
  AST_POWER_OFF: assert property ((!mains_present && !aux24_present) [*5] |-> !led_power)
    else $error("power led lit");
  AST_BUS_OK: assert property ((bus_option_fitted && bus_status == BUS_OK) [*3] |-> led_bus)
    else $error("bus led not steady");
  AST_BUS_DARK: assert property ((!bus_option_fitted || bus_status == BUS_OFF) [*3] |-> !led_bus)
    else $error("bus led lit");
  AST_COAST_NOT_READY: assert property (motor_coast |-> !drive_ready)
    else $error("ready while coasting");
  AST_ALARM_NEEDS_TRIP: assert property (led_alarm |-> motor_coast)
    else $error("alarm without trip");
  AST_STATUS_OK_OFF: assert property ((!fault_active && !motor_coast) [*6] |-> !led_status)
    else $error("status led lit when ready");
  AST_TRIP_LATCH: assert property (s_no_clear |=> motor_coast)
    else $error("trip cleared without reset");
  AST_ALARM_FLASH: assert property (s_trip_entry |-> ##[0:7] (led_alarm || !motor_coast))
    else $error("alarm led never lit");
  AST_WARN_CLEARS: assert property ((!fault_active && !motor_coast) [*6] |-> !led_warning)
    else $error("warning stuck");
endmodule : drive_fault_indicator_logic_chk
bind drive_fault_indicator_logic drive_fault_indicator_logic_chk chk_u (.*);
`default_nettype wire

/* File: tb/drive_fault_indicator_logic_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_fault_indicator_logic_tb_top;
  import fault_ind_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, fault_active = 1'b0, fault_escalate = 1'b0, fault_lock = 1'b0;
  logic thermal_as_alarm = 1'b0, auto_reset_en = 1'b0, mains_present = 1'b1, aux24_present = 1'b0;
  logic bus_option_fitted = 1'b0, status_setting = 1'b1, go = 1'b0, x;
  logic [1:0] bus_status = BUS_OK, src = 2'h0;
  logic [CODE_W-1:0] fault_code = CODE_NONE, log_code, q[$];
  logic [VALUE_W-1:0] measured_value = 14'h0000, log_value;
  logic [3:0] log_index = 4'h1;
  logic [TIME_W-1:0] log_time, t1;
  logic key_stop_reset, din_reset, serial_reset, led_status, led_bus, led_alarm, led_warning, led_power;
  logic motor_coast, drive_ready;
  int error_cnt = 0, check_count = 0, seed = 32'h2cac, n_al, n_wn, n_bc, n_ne, x_bc;
  logic [CODE_W-1:0] tc[10] = '{7'h05, 7'h06, 7'h21, 7'h63, 7'h0a, 7'h09, 7'h0e, 7'h33, 7'h0a, 7'h09};
  logic [1:0] tf[10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
  logic [CODE_W-1:0] lc[9] = '{7'h0e, 7'h0f, 7'h10, 7'h23, 7'h28, 7'h32, 7'h36, 7'h37, 7'h38};
  always #2 mclk = ~mclk;
  drive_fault_indicator_logic #(.SLOW_CYC(4), .FAST_CYC(2), .ALARM_CYC(3)) dut_u (.*);
  reset_panel_model pm_u (.mclk(mclk), .src(src), .go(go), .key_stop_reset(key_stop_reset),
    .din_reset(din_reset), .serial_reset(serial_reset));
  function automatic logic exp_trip(input logic [6:0] c, input logic e, input logic t);
    if (c inside {7'h0a, 7'h0b})
      return t;
    if (c inside {[7'h0e:7'h10], 7'h23, [7'h25:7'h2d], 7'h32, 7'h33, [7'h36:7'h38]})
      return 1'b1;
    if (c inside {7'h02, 7'h04, 7'h07, 7'h08, 7'h09, 7'h0c, 7'h0d, 7'h11, 7'h12, 7'h22, 7'h24})
      return e;
    return 1'b0;
  endfunction : exp_trip
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic watch(input int n);
    logic lb;
    lb = led_bus;
    {n_al, n_wn, n_bc, n_ne} = '0;
    repeat (n) begin
      @(negedge mclk);
      n_al += (led_alarm === 1'b1);
      n_wn += (led_warning === 1'b1);
      n_ne += (led_alarm !== led_warning);
      n_bc += (led_bus !== lb);
      lb = led_bus;
    end
  endtask : watch
  task automatic pulse(input logic [1:0] s);
    src = s;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(10);
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    cyc(8);
    reset = 1'b0;
    cyc(4);
    for (int i = 0; i < 10; i++) begin
      fault_code = tc[i];
      status_setting = i[0];
      {thermal_as_alarm, fault_escalate} = tf[i];
      measured_value = 14'($random(seed));
      fault_active = 1'b1;
      cyc(8);
      x = exp_trip(fault_code, fault_escalate, thermal_as_alarm);
      cmp(motor_coast, x);
      watch(12);
      if (x) begin
        cmp(n_al != 0, 1'b1);
        cmp(led_status, status_setting);
        cmp(log_code, fault_code);
        cmp(log_value, measured_value);
        pulse(2'(i % 3));
        cmp(motor_coast, 1'b1);
        fault_active = 1'b0;
        cyc(6);
        watch(12);
        cmp(n_wn != 0, 1'b0);
        cmp(n_al != 0, 1'b1);
        pulse(2'(i % 3));
        cmp(drive_ready, 1'b1);
      end else begin
        cmp(n_wn != 0, 1'b1);
        cmp(n_al != 0, 1'b0);
        cmp(led_status, status_setting);
        fault_active = 1'b0;
        cyc(8);
        cmp(led_warning, 1'b0);
        cmp(led_status, 1'b0);
      end
    end
    $display("test classify done");
    auto_reset_en = 1'b1;
    repeat (11) begin
      fault_code = lc[$unsigned($random(seed)) % 9];
      q.push_front(fault_code);
      fault_active = 1'b1;
      cyc(8);
      fault_active = 1'b0;
      cyc(8);
      cmp(drive_ready, 1'b1);
    end
    cyc(2);
    cmp(log_code, q[0]);
    t1 = log_time;
    log_index = 4'ha;
    cyc(2);
    cmp(log_code, q[9]);
    cmp(t1 > log_time, 1'b1);
    $display("test log done");
    fault_code = 7'h02;
    fault_escalate = 1'b1;
    fault_lock = 1'b1;
    fault_active = 1'b1;
    cyc(8);
    watch(12);
    cmp(n_ne, 0);
    cmp(n_al != 0, 1'b1);
    fault_active = 1'b0;
    pulse(2'h0);
    cmp(motor_coast, 1'b1);
    mains_present = 1'b0;
    cyc(8);
    mains_present = 1'b1;
    cyc(8);
    pulse(2'h1);
    cmp(drive_ready, 1'b1);
    $display("test lock done");
    for (int p = 0; p < 4; p++) begin
      {mains_present, aux24_present} = 2'(p);
      cyc(6);
      cmp(led_power, p != 0);
    end
    bus_option_fitted = 1'b1;
    bus_status = BUS_LOCAL;
    watch(24);
    x_bc = n_bc;
    cmp(x_bc != 0, 1'b1);
    bus_status = BUS_NO_MASTER;
    watch(24);
    cmp(n_bc > x_bc, 1'b1);
    bus_status = BUS_OK;
    cyc(3);
    cmp(led_bus, 1'b1);
    bus_status = BUS_OFF;
    cyc(3);
    cmp(led_bus, 1'b0);
    bus_option_fitted = 1'b0;
    bus_status = BUS_OK;
    cyc(3);
    cmp(led_bus, 1'b0);
    $display("test leds done");
    wrap_up();
  end
endmodule : drive_fault_indicator_logic_tb_top
`default_nettype wire
